// [verilog/safety_status_word_packer.v]
// Purpose: packs safety function states into the first three octets
//          of the fail-safe input user data sent to the safety controller
// Assumes: all inputs synchronous to pclk; frame_req is a one-cycle pulse
// Notes: registers on APB with one wait-free access cycle; reserved
//        bits are always zero; fail-safe and configuration clear all
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`include "status_packer_defines.vh"

module safety_status_word_packer #(
  parameter W = `MSG_WIDTH,
  parameter CNT_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire fail_safe_state,
  input wire config_state,
  input wire frame_req,
  input wire speed_limit_one_on,
  input wire speed_limit_two_on,
  input wire speed_limit_three_on,
  input wire speed_limit_four_on,
  input wire below_limit_one,
  input wire below_limit_two,
  input wire below_limit_three,
  input wire below_limit_four,
  input wire controlled_stop_on,
  input wire emergency_stop_on,
  input wire brake_control_on,
  input wire torque_removal_on,
  input wire accel_range_zero_on,
  input wire accel_range_one_on,
  input wire max_speed_supervision_on,
  output wire [W-1:0] msg_data,
  output wire msg_valid,
  output reg irq
);

  reg [1:0] ctrl_q;
  reg [1:0] ctrl_d;
  reg [`EV_WIDTH-1:0] irq_status_q;
  reg [`EV_WIDTH-1:0] irq_status_d;
  reg [`EV_WIDTH-1:0] irq_enable_q;
  reg [`EV_WIDTH-1:0] irq_enable_d;
  reg [`EV_WIDTH-1:0] irq_clear;
  reg [`EV_WIDTH-1:0] events;
  reg [CNT_W-1:0] frame_count_q;
  reg [W-1:0] prev_msg_q;
  reg zero_state_q;
  reg sw_send_q;
  reg sw_send_d;
  reg [W-1:0] live_word;
  reg [31:0] rd_value;
  reg rd_error;
  wire zero_force;
  wire capture;
  wire setup_phase;
  wire wr_access;

  // apb phase decode
  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & pready & pwrite;

  // the message is held at zero in fail-safe or configuration state
  assign zero_force = fail_safe_state | config_state |
                      ctrl_q[`CTRL_FORCE_ZERO];

  // a frame is requested by the link or by a software send strobe
  assign capture = (frame_req & ctrl_q[`CTRL_SEND_EN]) | sw_send_q;

  // live flag word, one bit per safety function
  always @* begin
    live_word = {W{1'b0}};
    live_word[`POS_SPEED_TWO] = speed_limit_two_on &
                                below_limit_two;
    live_word[`POS_SPEED_ONE] = speed_limit_one_on &
                                below_limit_one;
    live_word[`POS_CTRL_STOP] = controlled_stop_on;
    live_word[`POS_EMERG_STOP] = emergency_stop_on;
    live_word[`POS_BRAKE] = brake_control_on;
    live_word[`POS_TORQUE_OFF] = torque_removal_on;
    live_word[`POS_ACCEL_ONE] = accel_range_one_on;
    live_word[`POS_ACCEL_ZERO] = accel_range_zero_on;
    live_word[`POS_SPEED_FOUR] = speed_limit_four_on &
                                 below_limit_four;
    live_word[`POS_SPEED_THREE] = speed_limit_three_on &
                                  below_limit_three;
    live_word[`POS_MAX_SPEED] = max_speed_supervision_on;
  end

  // snapshot register that feeds the outgoing message
  frame_capture #(
    .W(W),
    .USED_MASK(`MSG_USED_MASK)
  ) u_capture (
    .pclk(pclk),
    .presetn(presetn),
    .capture(capture),
    .zero_force(zero_force),
    .live_word(live_word),
    .word_q(msg_data),
    .sent_q(msg_valid)
  );

  // read mux, evaluated during the setup cycle
  always @* begin
    rd_value = 32'h00000000;
    rd_error = 1'b0;
    case (paddr)
      `OFF_CTRL: begin
        rd_value[1:0] = ctrl_q;
      end
      `OFF_LIVE: begin
        rd_value[W-1:0] = live_word;
        rd_value[`LIVE_ZERO_STATE] = zero_force;
        rd_value[`LIVE_FAIL_SAFE] = fail_safe_state;
        rd_value[`LIVE_CONFIG] = config_state;
      end
      `OFF_MSG: begin
        rd_value[W-1:0] = msg_data;
      end
      `OFF_IRQ_STATUS: begin
        rd_value[`EV_WIDTH-1:0] = irq_status_q;
      end
      `OFF_IRQ_CLEAR: begin
        rd_value = 32'h00000000; // write-only, reads zero
      end
      `OFF_IRQ_ENABLE: begin
        rd_value[`EV_WIDTH-1:0] = irq_enable_q;
      end
      `OFF_FRAME_COUNT: begin
        rd_value[CNT_W-1:0] = frame_count_q;
      end
      `OFF_SEND: begin
        rd_value = 32'h00000000; // write-only, reads zero
      end
      default: begin
        rd_error = 1'b1;
      end
    endcase
  end

  // bus answer: ready in the first access cycle, no wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h00000000 : rd_value;
      pslverr <= rd_error;
    end else begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // register writes take effect at the completing edge
  always @* begin
    ctrl_d = ctrl_q;
    irq_enable_d = irq_enable_q;
    irq_clear = {`EV_WIDTH{1'b0}};
    sw_send_d = 1'b0;
    if (wr_access) begin
      case (paddr)
        `OFF_CTRL: begin
          ctrl_d = pwdata[1:0];
        end
        `OFF_IRQ_CLEAR: begin
          irq_clear = pwdata[`EV_WIDTH-1:0];
        end
        `OFF_IRQ_ENABLE: begin
          irq_enable_d = pwdata[`EV_WIDTH-1:0];
        end
        `OFF_SEND: begin
          sw_send_d = pwdata[0];
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
  end

  // control and enable registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      irq_enable_q <= `IRQ_ENABLE_RESET;
      sw_send_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_enable_q <= irq_enable_d;
      sw_send_q <= sw_send_d;
    end
  end

  // events: frame sent, content changed, entry into the zero state
  always @* begin
    events = {`EV_WIDTH{1'b0}};
    events[`EV_SENT] = msg_valid;
    events[`EV_CHANGED] = msg_valid & (msg_data != prev_msg_q);
    events[`EV_ZERO_ENTRY] = zero_force & ~zero_state_q;
  end

  // sticky status: a new event wins over a clear in the same cycle
  always @* begin
    irq_status_d = (irq_status_q & ~irq_clear) | events;
  end

  // status, history and interrupt line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= {`EV_WIDTH{1'b0}};
      prev_msg_q <= {W{1'b0}};
      zero_state_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      zero_state_q <= zero_force;
      if (msg_valid) begin
        prev_msg_q <= msg_data;
      end
      irq <= |(irq_status_d & irq_enable_d);
    end
  end

  // count of frames handed to the link, wraps at full scale
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_count_q <= {CNT_W{1'b0}};
    end else if (msg_valid) begin
      frame_count_q <= frame_count_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // safety_status_word_packer

// [verilog/status_packer_defines.vh]
// Purpose: shared constants of the safety status word packer
// Assumes: included by its bare name from each design file
// Notes: octet 0 is message bits 7:0, octet 1 is 15:8, octet 2 is 23:16
`ifndef STATUS_PACKER_DEFINES_VH
`define STATUS_PACKER_DEFINES_VH

// message geometry
`define MSG_WIDTH 24
`define MSG_USED_MASK 24'h02F0F3

// flag positions inside the 24-bit message
`define POS_SPEED_TWO 0
`define POS_SPEED_ONE 1
`define POS_CTRL_STOP 4
`define POS_EMERG_STOP 5
`define POS_BRAKE 6
`define POS_TORQUE_OFF 7
`define POS_ACCEL_ONE 12
`define POS_ACCEL_ZERO 13
`define POS_SPEED_FOUR 14
`define POS_SPEED_THREE 15
`define POS_MAX_SPEED 17

// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_LIVE 8'h04
`define OFF_MSG 8'h08
`define OFF_IRQ_STATUS 8'h0C
`define OFF_IRQ_CLEAR 8'h10
`define OFF_IRQ_ENABLE 8'h14
`define OFF_FRAME_COUNT 8'h18
`define OFF_SEND 8'h1C

// control register fields and reset value
`define CTRL_SEND_EN 0
`define CTRL_FORCE_ZERO 1
`define CTRL_RESET 2'h1

// event bits of the interrupt registers
`define EV_SENT 0
`define EV_CHANGED 1
`define EV_ZERO_ENTRY 2
`define EV_WIDTH 3
`define IRQ_ENABLE_RESET 3'h0

// live status register fields above the message bits
`define LIVE_ZERO_STATE 24
`define LIVE_FAIL_SAFE 25
`define LIVE_CONFIG 26

`endif

// [verilog/frame_capture.v]
// Purpose: one-cycle snapshot of the outgoing status message
// Assumes: capture is a one-cycle pulse on pclk
// Notes: zero_force clears the message at the next edge and blocks capture
`include "status_packer_defines.vh"

module frame_capture #(
  parameter W = `MSG_WIDTH,
  parameter [W-1:0] USED_MASK = `MSG_USED_MASK
) (
  input wire pclk,
  input wire presetn,
  input wire capture,
  input wire zero_force,
  input wire [W-1:0] live_word,
  output reg [W-1:0] word_q,
  output reg sent_q
);

  genvar i;

  // every bit is loaded on the same edge, reserved bits stay zero
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          word_q[i] <= 1'b0;
        end else if (zero_force) begin
          word_q[i] <= 1'b0;
        end else if (capture) begin
          word_q[i] <= live_word[i] & USED_MASK[i];
        end
      end
    end
  endgenerate

  // a frame leaves only when not held at zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent_q <= 1'b0;
    end else begin
      sent_q <= capture & ~zero_force;
    end
  end

endmodule // frame_capture

// [verif/packer_properties.sv]
// Purpose: timing checks on the packed status message
// Assumes: bound into the top module, one clock domain
// Notes: lw is the expected flag word built from the live inputs
module packer_properties #(
  parameter W = 24
) (
  input wire pclk,
  input wire presetn,
  input wire fail_safe_state,
  input wire config_state,
  input wire speed_limit_one_on,
  input wire speed_limit_two_on,
  input wire speed_limit_three_on,
  input wire speed_limit_four_on,
  input wire below_limit_one,
  input wire below_limit_two,
  input wire below_limit_three,
  input wire below_limit_four,
  input wire controlled_stop_on,
  input wire emergency_stop_on,
  input wire brake_control_on,
  input wire torque_removal_on,
  input wire accel_range_zero_on,
  input wire accel_range_one_on,
  input wire max_speed_supervision_on,
  input wire [W-1:0] msg_data,
  input wire msg_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] lw;
  // expected word from the live function states
  assign lw = {6'h00, max_speed_supervision_on, 1'b0,
    speed_limit_three_on & below_limit_three,
    speed_limit_four_on & below_limit_four,
    accel_range_zero_on, accel_range_one_on, 4'h0,
    torque_removal_on, brake_control_on, emergency_stop_on,
    controlled_stop_on, 2'h0, speed_limit_one_on & below_limit_one,
    speed_limit_two_on & below_limit_two};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence zero_req;
    fail_safe_state || config_state;
  endsequence
  sequence fresh;
    msg_valid;
  endsequence
  reserved_zero_a: assert property ((msg_data & 24'hFD0F0C) == 24'h0)
    else $error("reserved message bit set");
  zero_clear_a: assert property (zero_req |=> msg_data == 24'h0)
    else $error("message not cleared in zero state");
  zero_quiet_a: assert property (zero_req |=> !msg_valid)
    else $error("frame sent in zero state");
  low_speed_a: assert property (fresh |-> msg_data[1:0] == $past(lw[1:0]))
    else $error("speed one or two flag wrong");
  high_speed_a: assert property (fresh |-> msg_data[15:14] == $past(lw[15:14]))
    else $error("speed three or four flag wrong");
  stop_flags_a: assert property (fresh |-> msg_data[7:4] == $past(lw[7:4]))
    else $error("stop flag wrong");
  accel_flags_a: assert property (fresh |-> msg_data[13:12] == $past(lw[13:12]))
    else $error("acceleration flag wrong");
  max_speed_a: assert property (fresh |-> msg_data[17] == $past(lw[17]))
    else $error("maximum speed flag wrong");
endmodule // packer_properties

bind safety_status_word_packer packer_properties #(.W(W)) chk (.*);

// [verif/safety_host_model.sv]
// Purpose: safety controller end taking each sent frame
// Assumes: msg_valid marks a fresh frame for one cycle
// Notes: reserved bits are dropped on arrival
module safety_host_model (
  input wire pclk,
  input wire presetn,
  input wire msg_valid,
  input wire [23:0] msg_data,
  output logic [15:0] frames_seen,
  output logic [23:0] last_flags
);
  timeunit 1ns;
  timeprecision 100ps;
  // count frames and keep the meaningful bits of the last one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frames_seen <= 16'h0000;
      last_flags <= 24'h000000;
    end else if (msg_valid) begin
      frames_seen <= frames_seen + 16'h0001;
      last_flags <= msg_data & 24'h02F0F3;
    end
  end
endmodule // safety_host_model

// [verif/safety_status_word_packer_test.sv]
// Purpose: self-checking bench of the status word packer
// Assumes: one clock, registers reached over APB
// Notes: fn bundles the fifteen function inputs
`include "status_packer_defines.vh"
module safety_status_word_packer_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic fail_safe_state = 0, config_state = 0, frame_req = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, cnt;
  logic [14:0] fn = 15'h0000;
  logic [23:0] msg_data, last_flags;
  logic [15:0] frames_seen, sent = 16'h0000;
  logic pready, pslverr, msg_valid, irq;
  int mismatches = 0, tests_run = 0;
  // 40 MHz clock
  always #12.5 pclk = ~pclk;
  safety_status_word_packer dut (.*,
    .speed_limit_one_on(fn[0]), .speed_limit_two_on(fn[1]),
    .speed_limit_three_on(fn[2]), .speed_limit_four_on(fn[3]),
    .below_limit_one(fn[4]), .below_limit_two(fn[5]),
    .below_limit_three(fn[6]), .below_limit_four(fn[7]),
    .controlled_stop_on(fn[8]), .emergency_stop_on(fn[9]),
    .brake_control_on(fn[10]), .torque_removal_on(fn[11]),
    .accel_range_zero_on(fn[12]), .accel_range_one_on(fn[13]),
    .max_speed_supervision_on(fn[14]));
  safety_host_model host (.*);
  function automatic logic [23:0] pack(input logic [14:0] f);
    pack = {6'h00, f[14], 1'b0, f[2] & f[6], f[3] & f[7], f[12], f[13],
      4'h0, f[11], f[10], f[9], f[8], 2'h0, f[0] & f[4], f[1] & f[5]};
  endfunction
  task automatic chk(input logic [31:0] g, e, input string m);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold the request until the edge at which pready is sampled high
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_valid;
    int n;
    @(negedge pclk);
    for (n = 0; n < 8 && msg_valid !== 1'b1; n++) @(negedge pclk);
    chk(msg_valid, 1, "no frame");
  endtask
  task automatic frame(input logic [14:0] v);
    @(posedge pclk);
    fn <= v; frame_req <= 1'b1;
    @(posedge pclk);
    fn <= ~v; frame_req <= 1'b0;
    wait_valid;
    chk(msg_data, pack(v), "frame content");
    sent++;
  endtask
  task automatic t_reset;
    chk(msg_data, 0, "msg after reset");
    apb(0, `OFF_CTRL, 0, rd, er);
    chk(rd, 32'h1, "ctrl reset");
    chk(er, 0, "ctrl read error");
    apb(0, `OFF_IRQ_ENABLE, 0, rd, er);
    chk(rd, 32'h0, "enable reset");
  endtask
  task automatic t_map;
    // single inputs, then each speed limit with its own below flag
    for (int i = 0; i < 21; i++)
      frame(i < 15 ? 15'h0001 << i : (i < 19 ? 15'h0011 << (i - 15) :
        (i == 19 ? 15'h00FF : 15'h7FFF)));
    @(negedge pclk);
    chk(last_flags, pack(15'h7FFF), "host flags");
  endtask
  task automatic t_zero;
    for (int k = 0; k < 3; k++) begin
      frame(15'h7FFF);
      @(posedge pclk);
      fail_safe_state <= (k == 0);
      config_state <= (k == 1);
      if (k == 2) apb(1, `OFF_CTRL, 32'h3, rd, er);
      repeat (2) @(posedge pclk);
      frame_req <= 1'b1;
      fn <= 15'h7FFF;
      @(posedge pclk);
      frame_req <= 1'b0;
      repeat (3) begin
        @(negedge pclk);
        chk(msg_data, 0, "zero state data");
        chk(msg_valid, 0, "zero state frame");
      end
      apb(0, `OFF_LIVE, 0, rd, er);
      chk(rd, {5'h00, k == 1, k == 0, 1'b1, pack(15'h7FFF)}, "live word");
      apb(0, `OFF_MSG, 0, rd, er);
      chk(rd, 0, "zero state msg reg");
      @(posedge pclk);
      fail_safe_state <= 1'b0;
      config_state <= 1'b0;
      apb(1, `OFF_CTRL, 32'h1, rd, er);
    end
  endtask
  task automatic t_irq;
    apb(0, `OFF_IRQ_STATUS, 0, rd, er);
    chk(rd, 32'h7, "events pending");
    apb(1, `OFF_IRQ_CLEAR, 32'h7, rd, er);
    apb(1, `OFF_IRQ_ENABLE, 32'h1, rd, er);
    chk(irq, 0, "irq after clear");
    frame(15'h0300);
    @(negedge pclk);
    chk(irq, 1, "irq raise");
    apb(1, `OFF_IRQ_CLEAR, 32'h1, rd, er);
    @(negedge pclk);
    chk(irq, 0, "irq clear");
    apb(1, `OFF_IRQ_ENABLE, 32'h0, rd, er);
    apb(0, `OFF_FRAME_COUNT, 0, cnt, er);
    apb(1, `OFF_SEND, 32'h1, rd, er);
    wait_valid;
    chk(msg_data, pack(fn), "send content");
    sent++;
    @(negedge pclk);
    chk(irq, 0, "irq masked");
    apb(0, `OFF_IRQ_STATUS, 0, rd, er);
    chk(rd, 32'h3, "sent status");
    apb(0, `OFF_FRAME_COUNT, 0, rd, er);
    chk(rd, cnt + 32'h1, "frame count");
    apb(0, 8'h40, 0, rd, er);
    chk(rd, 0, "unmapped data");
    chk(er, 1, "unmapped error");
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #100000;
    mismatches++;
    print_verdict;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_map;
    t_zero;
    t_irq;
    @(negedge pclk);
    chk(frames_seen, sent, "host frames");
    print_verdict;
  end
endmodule // safety_status_word_packer_test
